/* rtl/arf_core.sv */
// result formatter and channel/reference register file
// assumes the analog side returns a signed raw code with a done pulse
//
// Added by the designer: the address-and-strobe port.
`default_nettype none

module arf_core
(
   // clock and reset
   input  wire  logic              core_clk,
   input  wire  logic              reset,
   // register port
   input  wire  logic [7:0]        reg_addr,
   input  wire  logic [7:0]        reg_wdata,
   input  wire  logic              reg_wr,
   input  wire  logic              reg_rd,
   output logic       [7:0]        reg_rdata,
   // analog side
   input  wire  logic              conv_busy,
   input  wire  arf_pkg::arf_raw_t raw_in,
   output arf_pkg::arf_chref_t     active_sel,
   output logic                    temp_sensor_channel,
   output logic                    polarity_swap,
   output logic                    bipolar_enable,
   // interrupt
   output logic                    irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   arf_pkg::arf_chref_t chref_q, chref_d;     // software copy
   arf_pkg::arf_chref_t act_q, act_d;         // locked selection
   logic [7:0]          ctrlb_q, ctrlb_d;     // control b
   logic [9:0]          res_q, res_d;         // stored code
   logic [1:0]          stat_q, stat_d;       // sticky events
   logic [1:0]          mask_q, mask_d;       // interrupt mask
   logic [7:0]          rdata_q, rdata_d;     // read data
   logic [9:0]          fmt;                  // formatted code
   logic                sat;                  // saturation event
   logic [15:0]         view;                 // aligned result pair

   // decode a register read to its value
   function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                         input logic [7:0] chref,
                                         input logic [7:0] ctrlb,
                                         input logic [15:0] pair,
                                         input logic [1:0] st,
                                         input logic [1:0] mk);
      logic [7:0] v;
      v = 8'h00;
      if (a == arf_pkg::ARF_CHREF_OFS)
         v = chref;
      else if (a == arf_pkg::ARF_CTRLB_OFS)
         v = ctrlb;
      else if (a == arf_pkg::ARF_RESLO_OFS)
         v = pair[7:0];
      else if (a == arf_pkg::ARF_RESHI_OFS)
         v = pair[15:8];
      else if (a == arf_pkg::ARF_STAT_OFS)
         v = {6'h00, st};
      else if (a == arf_pkg::ARF_MASK_OFS)
         v = {6'h00, mk};
      return v;
   endfunction

   // ------------------------------------------------------------------
   // result formatting
   // ------------------------------------------------------------------
   // pick encoding from mode and clamp
   always_comb
   begin
      fmt = raw_in.code[9:0];
      sat = 1'b0;
      if (!raw_in.diff)
      begin
         // single-ended: unsigned, a negative code clamps low to zero without setting the saturation flag
         if (raw_in.code[10])
            fmt = arf_pkg::ARF_CODE_ZERO;
      end
      else if (ctrlb_q[arf_pkg::ARF_CTRLB_BIP])
      begin
         // bipolar: half scale, two's complement, top bit sign
         fmt = raw_in.code[10:1];
      end
      else if (raw_in.code[10])
      begin
         // unipolar: negative difference saturates to zero
         fmt = arf_pkg::ARF_CODE_ZERO;
         sat = 1'b1;
      end
   end

   // alignment is applied at read time so it acts immediately
   always_comb
   begin
      if (chref_q.left_adjust)
         view = {res_q, 6'h00};
      else
         view = {6'h00, res_q};
   end

   // ------------------------------------------------------------------
   // registers: next values
   // ------------------------------------------------------------------
   always_comb
   begin
      chref_d = chref_q;
      ctrlb_d = ctrlb_q;
      mask_d  = mask_q;
      res_d   = res_q;
      act_d   = act_q;
      stat_d  = stat_q;
      // software writes
      if (reg_wr)
      begin
         if (reg_addr == arf_pkg::ARF_CHREF_OFS)
            chref_d = reg_wdata;
         else if (reg_addr == arf_pkg::ARF_CTRLB_OFS)
            ctrlb_d = reg_wdata;
         else if (reg_addr == arf_pkg::ARF_MASK_OFS)
            mask_d = reg_wdata[1:0];
         else if (reg_addr == arf_pkg::ARF_STAT_OFS)
            stat_d = stat_q & ~reg_wdata[1:0];
      end
      // selection tracks software only while idle or at completion
      if (!conv_busy || raw_in.valid)
         act_d = chref_d;
      // completion stores result and sets flags; set beats clear
      if (raw_in.valid)
      begin
         res_d = fmt;
         stat_d[arf_pkg::ARF_STAT_DONE] = 1'b1;
         if (sat)
            stat_d[arf_pkg::ARF_STAT_SAT] = 1'b1;
      end
      rdata_d = reg_rd ? rd_mux(reg_addr, chref_q, ctrlb_q, view,
                                stat_q, mask_q) : 8'h00;
   end

   // register update
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         chref_q <= arf_pkg::ARF_RST8;
         act_q   <= arf_pkg::ARF_RST8;
         ctrlb_q <= arf_pkg::ARF_RST8;
         res_q   <= arf_pkg::ARF_CODE_ZERO;
         stat_q  <= 2'h0;
         mask_q  <= 2'h0;
         rdata_q <= arf_pkg::ARF_RST8;
      end
      else
      begin
         chref_q <= chref_d;
         act_q   <= act_d;
         ctrlb_q <= ctrlb_d;
         res_q   <= res_d;
         stat_q  <= stat_d;
         mask_q  <= mask_d;
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign reg_rdata           = rdata_q;
   assign active_sel          = act_q;
   // sensor on while the locked channel is the temperature one
   assign temp_sensor_channel =
      (act_q.channel_select == arf_pkg::ARF_CH_TEMP);
   assign polarity_swap       = ctrlb_q[arf_pkg::ARF_CTRLB_SWAP];
   assign bipolar_enable      = ctrlb_q[arf_pkg::ARF_CTRLB_BIP];
   assign irq                 = |(stat_q & mask_q);

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   chk_unipolar_sat: assert property (@(posedge core_clk) disable iff (reset)
      raw_in.valid && raw_in.diff && !bipolar_enable && raw_in.code[10]
      |=> res_q == 10'h000 && stat_q[1])
      else $error("unipolar negative not saturated");
   chk_bipolar_code: assert property (@(posedge core_clk) disable iff (reset)
      raw_in.valid && raw_in.diff && bipolar_enable
      |=> res_q == $past(raw_in.code[10:1]))
      else $error("bipolar code wrong");
   chk_sign_bit: assert property (@(posedge core_clk) disable iff (reset)
      raw_in.valid && raw_in.diff && bipolar_enable
      |=> res_q[9] == $past(raw_in.code[10]))
      else $error("sign bit wrong");
   chk_single_code: assert property (@(posedge core_clk) disable iff (reset)
      raw_in.valid && !raw_in.diff && !raw_in.code[10]
      |=> res_q == $past(raw_in.code[9:0]))
      else $error("single-ended code wrong");
   chk_done_set: assert property (@(posedge core_clk) disable iff (reset)
      raw_in.valid |=> stat_q[0])
      else $error("done flag not set");
   chk_sel_locked: assert property (@(posedge core_clk) disable iff (reset)
      conv_busy && !raw_in.valid |=> $stable(act_q))
      else $error("selection moved mid conversion");
   chk_temp_route: assert property (@(posedge core_clk) disable iff (reset)
      act_q.channel_select == 4'hf |-> temp_sensor_channel)
      else $error("temperature sensor not enabled");
   chk_left_view: assert property (@(posedge core_clk) disable iff (reset)
      reg_rd && reg_addr == 8'h05 && chref_q.left_adjust
      |=> reg_rdata == $past(res_q[9:2]))
      else $error("left adjust view wrong");
   chk_right_high: assert property (@(posedge core_clk) disable iff (reset)
      reg_rd && reg_addr == 8'h05 && !chref_q.left_adjust
      |=> reg_rdata[7:2] == 6'h00)
      else $error("high register upper bits not zero");
   chk_chref_reset: assert property (@(posedge core_clk)
      reset |=> chref_q == 8'h00)
      else $error("channel register reset wrong");
   cov_bipolar: cover property (@(posedge core_clk)
      raw_in.valid && bipolar_enable);
   cov_temp: cover property (@(posedge core_clk)
      raw_in.valid && temp_sensor_channel);
   cov_irq: cover property (@(posedge core_clk) irq);

endmodule

`default_nettype wire

/* include/arf_pkg.sv */
// constants, field layouts and carrier types of the converter result block
// assumes a single 200 MHz core clock and a plain strobe register port
`default_nettype none

package arf_pkg;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ARF_CHREF_OFS   = 8'h07; // channel/reference
   localparam logic [7:0] ARF_CTRLB_OFS   = 8'h03; // control b
   localparam logic [7:0] ARF_RESLO_OFS   = 8'h04; // result low
   localparam logic [7:0] ARF_RESHI_OFS   = 8'h05; // result high
   localparam logic [7:0] ARF_STAT_OFS    = 8'h08; // sticky status
   localparam logic [7:0] ARF_MASK_OFS    = 8'h09; // interrupt mask

   // ------------------------------------------------------------------
   // field positions and values
   // ------------------------------------------------------------------
   localparam int         ARF_CTRLB_BIP   = 7;     // bipolar enable bit
   localparam int         ARF_CTRLB_SWAP  = 5;     // polarity swap bit
   localparam int         ARF_STAT_DONE   = 0;     // done flag bit
   localparam int         ARF_STAT_SAT    = 1;     // saturation bit
   localparam logic [7:0] ARF_RST8        = 8'h00; // reset of registers
   localparam logic [3:0] ARF_CH_TEMP     = 4'hf;  // temperature channel
   localparam logic [9:0] ARF_CODE_MAX    = 10'h3ff;
   localparam logic [9:0] ARF_CODE_ZERO   = 10'h000;
   localparam logic [9:0] ARF_BIP_MAX     = 10'h1ff;
   localparam logic [9:0] ARF_BIP_MIN     = 10'h200;

   // ------------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0] reference_hi;   // reference bits 1:0
      logic       left_adjust;    // left aligned presentation
      logic       reference_b2;   // reference bit 2
      logic [3:0] channel_select; // input selection
   } arf_chref_t;

   // raw signed difference from the analog front end
   typedef struct packed
   {
      logic        valid;       // one-cycle end of conversion
      logic        diff;        // differential channel in use
      logic [10:0] code;        // signed 11-bit raw (sign + 10 bits)
   } arf_raw_t;

endpackage

`default_nettype wire

/* test/arf_analog_model.sv */
// analog front end model: converts on request after a short or long delay
// assumes the formatter locks its selection while conv_busy is high
`default_nettype none

module arf_analog_model
#(
   parameter logic [10:0] TEMP_CODE = 11'h12c // sensor reading, plain value
)
(
   // clock and reset
   input  wire  logic                core_clk,
   input  wire  logic                reset,
   // bench control
   input  wire  logic                start,
   input  wire  logic [10:0]         code_in,
   input  wire  logic                slow,
   // formatter side
   input  wire  arf_pkg::arf_chref_t active_sel,
   input  wire  logic                temp_sensor_channel,
   input  wire  logic                polarity_swap,
   output logic                      conv_busy,
   output arf_pkg::arf_raw_t         raw_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0]  cnt_q;  // cycles left
   logic [10:0] last_q; // last code handed over
   logic        diff;   // locked channel is a pair
   logic [10:0] val;    // code seen by the converter

   assign diff = active_sel.channel_select inside {[4'h4:4'hb]};
   // sensor on channel 1111, pair order reversed on request
   assign val  = temp_sensor_channel ? TEMP_CODE :
                 (polarity_swap && diff) ? -code_in : code_in;

   // count down, hand over one result, idle bus never shows a stale code
   always_ff @(posedge core_clk)
   begin
      raw_in.valid <= 1'b0;
      raw_in.diff  <= 1'b0;
      raw_in.code  <= ~last_q;
      if (reset)
      begin
         conv_busy <= 1'b0;
         cnt_q     <= 5'h00;
         last_q    <= 11'h000;
      end
      else if (start)
      begin
         conv_busy <= 1'b1;
         cnt_q     <= slow ? 5'h14 : 5'h03;
      end
      else if (raw_in.valid)
         conv_busy <= 1'b0;
      else if (conv_busy && cnt_q != 5'h00)
      begin
         cnt_q <= cnt_q - 5'h01;
         if (cnt_q == 5'h01)
         begin
            raw_in.valid <= 1'b1;
            raw_in.diff  <= diff;
            raw_in.code  <= val;
            last_q       <= val;
         end
      end
   end
endmodule

`default_nettype wire

/* test/adc_result_format_and_channel_select_test.sv */
// self-checking bench: register tasks, conversions through the model
// assumes arf_core with a one-cycle read latency and one core clock
`default_nettype none

module adc_result_format_and_channel_select_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, start = 0;
   logic slow = 0, conv_busy, temp_sensor_channel, polarity_swap;
   logic bipolar_enable, irq;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [10:0] code_in = 0;
   arf_pkg::arf_raw_t   raw_in;
   arf_pkg::arf_chref_t active_sel;
   int miscompares = 0, n_checks = 0;

   always #2.5 core_clk = ~core_clk;

   arf_core arf_core_i (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_busy(conv_busy),
      .raw_in(raw_in), .active_sel(active_sel), .irq(irq),
      .temp_sensor_channel(temp_sensor_channel),
      .polarity_swap(polarity_swap), .bipolar_enable(bipolar_enable));
   arf_analog_model arf_analog_model_i (.core_clk(core_clk),
      .reset(reset), .start(start), .code_in(code_in), .slow(slow),
      .active_sel(active_sel), .temp_sensor_channel(temp_sensor_channel),
      .polarity_swap(polarity_swap), .conv_busy(conv_busy),
      .raw_in(raw_in));

   // compare one byte
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, e);
   endtask
   // result pair in either alignment
   task automatic res(input logic [9:0] r, input logic left);
      if (left) begin rd(8'h05, r[9:2]); rd(8'h04, {r[1:0], 6'h00}); end
      else begin rd(8'h04, r[7:0]); rd(8'h05, {6'h00, r[9:8]}); end
   endtask
   task automatic conv(input logic [10:0] c, input logic s, input logic w);
      @(posedge core_clk);
      start <= 1'b1; code_in <= c; slow <= s;
      @(posedge core_clk);
      start <= 1'b0;
      if (w) repeat (s ? 26 : 9) @(posedge core_clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (4000) @(posedge core_clk);
      miscompares++;
      tally_and_finish;
   end

   initial
   begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      rd(8'h07, 8'h00); rd(8'h03, 8'h00); rd(8'h05, 8'h00);
      cmp({7'h0, bipolar_enable}, 8'h00);
      $display("test reset values done");
      wr(8'h07, 8'h8f);
      rd(8'h07, 8'h8f);
      cmp({7'h0, temp_sensor_channel}, 8'h01);
      conv(11'h000, 0, 1);
      res(10'h12c, 0);
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
      $display("test temperature done");
      wr(8'h07, 8'h00);
      conv(11'h155, 0, 1);
      res(10'h155, 0);
      wr(8'h07, 8'h20);
      res(10'h155, 1);
      wr(8'h07, 8'h00);
      conv(11'h3ff, 0, 1);
      res(10'h3ff, 0);
      conv(11'h7f0, 0, 1);
      res(10'h000, 0);
      $display("test single ended done");
      wr(8'h07, 8'h06);
      conv(11'h7c0, 0, 1);
      res(10'h000, 0);
      rd(8'h08, 8'h03);
      wr(8'h03, 8'h20);
      cmp({7'h0, polarity_swap}, 8'h01);
      conv(11'h7c0, 0, 1);
      res(10'h040, 0);
      $display("test unipolar done");
      wr(8'h03, 8'h80);
      cmp({7'h0, bipolar_enable}, 8'h01);
      conv(11'h400, 0, 1);
      res(10'h200, 0);
      conv(11'h3ff, 0, 1);
      res(10'h1ff, 0);
      $display("test bipolar done");
      conv(11'h010, 1, 0);
      wr(8'h07, 8'h03);
      cmp(active_sel, 8'h06);
      repeat (26) @(posedge core_clk);
      #1 cmp(active_sel, 8'h03);
      $display("test locked selection done");
      wr(8'h09, 8'h01);
      @(posedge core_clk);
      #1 cmp({7'h0, irq}, 8'h01);
      wr(8'h08, 8'h01);
      @(posedge core_clk);
      #1 cmp({7'h0, irq}, 8'h00);
      rd(8'h08, 8'h02);
      $display("test interrupt done");
      tally_and_finish;
   end
endmodule

`default_nettype wire
